// file: inc/dual_port_mailbox_cfg.svh
// Constants for the dual-port mailbox memory
`ifndef DUAL_PORT_MAILBOX_CFG_SVH
`define DUAL_PORT_MAILBOX_CFG_SVH
`define MBX_ADDR_W        11
`define MBX_DATA_W        8
`define MBX_DEPTH         2048
`define MBX_VECTOR_ADDR   11'h7ff
`define MBX_CP_IRQ_ADDR   11'h7fe
`define MBX_INSTANCES     2
`define MBX_RDATA_RST     8'h00
`define MBX_IRQ_N_IDLE    1'h1
`define MBX_IRQ_N_ACTIVE  1'h0
`define MBX_IRQ_IDLE      1'h0
`define MBX_IRQ_ACTIVE    1'h1
`endif

// file: inc/dual_port_mailbox_pkg.sv
// Types for the dual-port mailbox memory
`include "dual_port_mailbox_cfg.svh"
package dual_port_mailbox_pkg;
  typedef logic [`MBX_ADDR_W-1:0] addr_type;
  typedef logic [`MBX_DATA_W-1:0] data_type;
  // Per-instance flip-flop state
  typedef struct packed {
    data_type master_rdata;
    data_type cp_rdata;
    logic     cp_to_master_irq_n;
    logic     master_to_cp_irq;
  } inst_state_type;
endpackage

// file: verilog/dual_port_mailbox.sv
// Two shared memories with mailbox interrupts between a master and two control processors
// Each instance holds one byte array that both ports reach on the same clock.
// The master side preloads start-up code and posts mailbox words; each control
// processor runs out of its own instance and answers through the top word.
// Both interrupt outputs are levels taken straight from the state register.
//
// Collisions on one edge are resolved without stalling either port:
//  - two writes to one address leave the control processor's byte stored;
//  - a read of an address that the other port writes returns the new byte;
//  - a set of an interrupt flag wins over a clear in the same cycle.
//
// Hazard: a master read of the top word releases the request whether or not
// the request was seen, so software must only read it after the interrupt.
// The memory itself is not cleared by reset; only flags and read latches are.
`timescale 1ns/1ps
`default_nettype none
`include "dual_port_mailbox_cfg.svh"
module dual_port_mailbox (
  // Clock, reset and clock enable
  input  wire logic                                      clk_sys,
  input  wire logic                                      sys_rst,
  input  wire logic                                      clk_en,
  // Master port, one strobe pair per instance
  input  wire logic [`MBX_INSTANCES-1:0]                 master_select,
  input  wire logic [`MBX_INSTANCES-1:0]                 master_wr,
  input  wire logic [`MBX_INSTANCES-1:0]                 master_rd,
  input  wire logic [`MBX_INSTANCES*`MBX_ADDR_W-1:0]     master_addr,
  input  wire logic [`MBX_INSTANCES*`MBX_DATA_W-1:0]     master_wdata,
  output logic      [`MBX_INSTANCES*`MBX_DATA_W-1:0]     master_rdata,
  // Control processor ports, one per instance
  input  wire logic [`MBX_INSTANCES-1:0]                 cp_shared_mem_select_n,
  input  wire logic [`MBX_INSTANCES-1:0]                 cp_wr,
  input  wire logic [`MBX_INSTANCES-1:0]                 cp_rd,
  input  wire logic [`MBX_INSTANCES*`MBX_ADDR_W-1:0]     cp_addr,
  input  wire logic [`MBX_INSTANCES*`MBX_DATA_W-1:0]     cp_wdata,
  output logic      [`MBX_INSTANCES*`MBX_DATA_W-1:0]     cp_rdata,
  // Interrupt pairs, one per instance
  output logic      [`MBX_INSTANCES-1:0]                 cp_to_master_irq_n,
  output logic      [`MBX_INSTANCES-1:0]                 master_to_cp_irq
);

  // -------------------------------------------------------------------------
  // Lane slicing of the packed per-instance buses
  // -------------------------------------------------------------------------

  // Address lane i of a packed address bus
  function automatic dual_port_mailbox_pkg::addr_type lane_addr(
    input logic [`MBX_INSTANCES*`MBX_ADDR_W-1:0] bus,
    input int unsigned                           i
  );
    lane_addr = bus[i*`MBX_ADDR_W +: `MBX_ADDR_W];
  endfunction

  // Data lane i of a packed data bus
  function automatic dual_port_mailbox_pkg::data_type lane_data(
    input logic [`MBX_INSTANCES*`MBX_DATA_W-1:0] bus,
    input int unsigned                           i
  );
    lane_data = bus[i*`MBX_DATA_W +: `MBX_DATA_W];
  endfunction

  // -------------------------------------------------------------------------
  // Access decoding
  // -------------------------------------------------------------------------

  // Address match against a mailbox word or the other port's address
  function automatic logic hits(input dual_port_mailbox_pkg::addr_type a,
                                input dual_port_mailbox_pkg::addr_type m);
    hits = (a == m);
  endfunction

  // A write is taken when the port is selected and its write strobe is high
  function automatic logic take_wr(input logic sel, input logic wr);
    take_wr = sel & wr;
  endfunction

  // A read is taken when selected with read high; write wins if both are high
  function automatic logic take_rd(input logic sel, input logic rd, input logic wr);
    take_rd = sel & rd & ~wr;
  endfunction

  // Read data for one port: the other port's byte when it writes the same word
  function automatic dual_port_mailbox_pkg::data_type fwd_read(
    input logic                            other_wr,
    input dual_port_mailbox_pkg::addr_type other_a,
    input dual_port_mailbox_pkg::data_type other_d,
    input dual_port_mailbox_pkg::addr_type own_a,
    input dual_port_mailbox_pkg::data_type stored
  );
    if (other_wr && hits(other_a, own_a)) begin
      fwd_read = other_d;
    end else begin
      fwd_read = stored;
    end
  endfunction

  // State after reset: read latches cleared, both requests idle
  function automatic dual_port_mailbox_pkg::inst_state_type reset_state();
    reset_state.master_rdata       = `MBX_RDATA_RST;
    reset_state.cp_rdata           = `MBX_RDATA_RST;
    reset_state.cp_to_master_irq_n = `MBX_IRQ_N_IDLE;
    reset_state.master_to_cp_irq   = `MBX_IRQ_IDLE;
  endfunction

  // -------------------------------------------------------------------------
  // One memory and mailbox per control processor
  // -------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `MBX_INSTANCES; g = g + 1) begin : gen_inst
      // Shared byte array and registered state of this instance
      dual_port_mailbox_pkg::data_type       mem [0:`MBX_DEPTH-1];
      dual_port_mailbox_pkg::inst_state_type st_r;
      dual_port_mailbox_pkg::inst_state_type st_nxt;

      // Lanes and taken strobes of both ports
      dual_port_mailbox_pkg::addr_type       m_a;
      dual_port_mailbox_pkg::addr_type       c_a;
      dual_port_mailbox_pkg::data_type       m_d;
      dual_port_mailbox_pkg::data_type       c_d;
      logic                                  m_wr;
      logic                                  m_rd;
      logic                                  c_wr;
      logic                                  c_rd;

      // Address and data lanes of this instance
      assign m_a  = lane_addr(master_addr, g);
      assign c_a  = lane_addr(cp_addr, g);
      assign m_d  = lane_data(master_wdata, g);
      assign c_d  = lane_data(cp_wdata, g);

      // Taken strobes; the control processor select is active low
      assign m_wr = take_wr(master_select[g], master_wr[g]);
      assign m_rd = take_rd(master_select[g], master_rd[g], master_wr[g]);
      assign c_wr = take_wr(~cp_shared_mem_select_n[g], cp_wr[g]);
      assign c_rd = take_rd(~cp_shared_mem_select_n[g], cp_rd[g], cp_wr[g]);

      // Next state: read latches first, then each flag's clear before its set
      always_comb begin
        st_nxt = st_r;
        // Master read latch, fed around a same-edge control processor write
        if (m_rd) begin
          st_nxt.master_rdata = fwd_read(c_wr, c_a, c_d, m_a, mem[m_a]);
        end
        // Control processor read latch, fed around a same-edge master write
        if (c_rd) begin
          st_nxt.cp_rdata = fwd_read(m_wr, m_a, m_d, c_a, mem[c_a]);
        end
        // Master read of the vector word releases its request
        if (m_rd && hits(m_a, `MBX_VECTOR_ADDR)) begin
          st_nxt.cp_to_master_irq_n = `MBX_IRQ_N_IDLE;
        end
        // A new vector write wins over a simultaneous release
        if (c_wr && hits(c_a, `MBX_VECTOR_ADDR)) begin
          st_nxt.cp_to_master_irq_n = `MBX_IRQ_N_ACTIVE;
        end
        // Control processor read of its mailbox word acknowledges it
        if (c_rd && hits(c_a, `MBX_CP_IRQ_ADDR)) begin
          st_nxt.master_to_cp_irq = `MBX_IRQ_IDLE;
        end
        // A master mailbox write wins over a simultaneous acknowledge
        if (m_wr && hits(m_a, `MBX_CP_IRQ_ADDR)) begin
          st_nxt.master_to_cp_irq = `MBX_IRQ_ACTIVE;
        end
      end

      // State register; a low clock enable freezes it
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          st_r <= reset_state();
        end else if (clk_en) begin
          st_r <= st_nxt;
        end
      end

      // Shared array; on a same-address collision the control side lands last
      always_ff @(posedge clk_sys) begin
        if (clk_en) begin
          if (m_wr) begin
            mem[m_a] <= m_d;
          end
          if (c_wr) begin
            mem[c_a] <= c_d;
          end
        end
      end

      // Outputs straight from the state register of this instance
      assign master_rdata[g*`MBX_DATA_W +: `MBX_DATA_W] = st_r.master_rdata;
      assign cp_rdata[g*`MBX_DATA_W +: `MBX_DATA_W]     = st_r.cp_rdata;
      assign cp_to_master_irq_n[g]                      = st_r.cp_to_master_irq_n;
      assign master_to_cp_irq[g]                        = st_r.master_to_cp_irq;
    end
  endgenerate

endmodule
`default_nettype wire

// file: tb/mbx_chk.sv
// Checker for the mailbox interrupt pairs of both instances
`timescale 1ns/1ps
`default_nettype none
`include "dual_port_mailbox_cfg.svh"
module mbx_chk (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic [1:0]  master_select,
  input wire logic [1:0]  master_wr,
  input wire logic [1:0]  master_rd,
  input wire logic [1:0]  cp_shared_mem_select_n,
  input wire logic [1:0]  cp_wr,
  input wire logic [1:0]  cp_to_master_irq_n,
  input wire logic [1:0]  master_to_cp_irq,
  input wire logic [21:0] master_addr,
  input wire logic [21:0] cp_addr
);
  // Taken accesses on the mailbox words of the first instance
  wire cw  = clk_en & ~cp_shared_mem_select_n[0] & cp_wr[0]
             & (cp_addr[10:0] == `MBX_VECTOR_ADDR);
  wire mr  = clk_en & master_select[0] & master_rd[0] & ~master_wr[0]
             & (master_addr[10:0] == `MBX_VECTOR_ADDR);
  wire mw  = clk_en & master_select[0] & master_wr[0]
             & (master_addr[10:0] == `MBX_CP_IRQ_ADDR);
  // Taken accesses on the mailbox words of the second instance
  wire cw1 = clk_en & ~cp_shared_mem_select_n[1] & cp_wr[1]
             & (cp_addr[21:11] == `MBX_VECTOR_ADDR);
  wire mr1 = clk_en & master_select[1] & master_rd[1] & ~master_wr[1]
             & (master_addr[21:11] == `MBX_VECTOR_ADDR);
  wire mw1 = clk_en & master_select[1] & master_wr[1]
             & (master_addr[21:11] == `MBX_CP_IRQ_ADDR);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_vec_set; cw |=> !cp_to_master_irq_n[0]; endproperty
  a_vec_set: assert property (p_vec_set) else $error("irq_n not low");
  property p_vec_hold; !cp_to_master_irq_n[0] && !mr |=> !cp_to_master_irq_n[0]; endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("irq_n released early");
  property p_vec_clr; mr && !cw |=> cp_to_master_irq_n[0]; endproperty
  a_vec_clr: assert property (p_vec_clr) else $error("irq_n not released");
  property p_mbx_set; mw |=> master_to_cp_irq[0]; endproperty
  a_mbx_set: assert property (p_mbx_set) else $error("cp irq not raised");
  property p_vec_set1; cw1 |=> !cp_to_master_irq_n[1]; endproperty
  a_vec_set1: assert property (p_vec_set1) else $error("irq_n 1 not low");
  property p_vec_clr1; mr1 && !cw1 |=> cp_to_master_irq_n[1]; endproperty
  a_vec_clr1: assert property (p_vec_clr1) else $error("irq_n 1 not released");
  property p_mbx_set1; mw1 |=> master_to_cp_irq[1]; endproperty
  a_mbx_set1: assert property (p_mbx_set1) else $error("cp irq 1 not raised");
endmodule
bind dual_port_mailbox mbx_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
  .master_select(master_select), .master_wr(master_wr), .master_rd(master_rd),
  .cp_shared_mem_select_n(cp_shared_mem_select_n), .cp_wr(cp_wr),
  .cp_to_master_irq_n(cp_to_master_irq_n), .master_to_cp_irq(master_to_cp_irq),
  .master_addr(master_addr), .cp_addr(cp_addr));
`default_nettype wire

// file: tb/cp_model.sv
// Control processor model on the second memory port
`timescale 1ns/1ps
`default_nettype none
module cp_model (
  input  wire logic        clk_sys,
  output logic      [1:0]  sel_n,
  output logic      [1:0]  wr,
  output logic      [1:0]  rd,
  output logic      [21:0] addr,
  output logic      [15:0] wdata
);
  // Idle port: deselected, no strobes
  initial begin
    sel_n = 2'h3;
    wr = 2'h0;
    rd = 2'h0;
    addr = 22'h0;
    wdata = 16'h0;
  end
  // One access on its own port only; released lines show inverted values
  task automatic acc(input int i, input logic w, input logic [10:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sel_n[i] = 1'h0;
    wr[i] = w;
    rd[i] = !w;
    addr[11*i+:11] = a;
    wdata[8*i+:8] = d;
    @(negedge clk_sys);
    sel_n[i] = 1'h1;
    wr[i] = 1'h0;
    rd[i] = 1'h0;
    addr[11*i+:11] = ~a;
    wdata[8*i+:8] = ~d;
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Testbench for the dual-port mailbox
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module tb;
  logic        clk_sys = 0, sys_rst = 1;
  logic [1:0]  msel = 2'h0, mwr = 2'h0, mrd = 2'h0, csn, cwr, crd, irq_n, irq;
  logic [21:0] maddr = 22'h0, caddr;
  logic [15:0] mwd = 16'h0, cwd, mrdata, crdata;
  logic        cen = 1'h1;
  int          n_errors = 0, checks = 0;
  always #5 clk_sys = ~clk_sys;
  cp_model u_cp (.clk_sys(clk_sys), .sel_n(csn), .wr(cwr), .rd(crd), .addr(caddr), .wdata(cwd));
  dual_port_mailbox u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(cen),
    .master_select(msel), .master_wr(mwr), .master_rd(mrd), .master_addr(maddr),
    .master_wdata(mwd), .master_rdata(mrdata), .cp_shared_mem_select_n(csn), .cp_wr(cwr),
    .cp_rd(crd), .cp_addr(caddr), .cp_wdata(cwd), .cp_rdata(crdata),
    .cp_to_master_irq_n(irq_n), .master_to_cp_irq(irq));
  // Master access, returns half a cycle after the taking edge
  task automatic m_acc(input int i, input logic w, input logic [10:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    msel[i] = 1'h1;
    mwr[i] = w;
    mrd[i] = !w;
    maddr[11*i+:11] = a;
    mwd[8*i+:8] = d;
    @(negedge clk_sys);
    msel[i] = 1'h0;
    mwr[i] = 1'h0;
    mrd[i] = 1'h0;
  endtask
  // Master preloads both memories, each processor reads back its own
  task t_boot;
    m_acc(0, 1, 11'h7fd, 8'h3c);
    m_acc(1, 1, 11'h7fd, 8'h5a);
    u_cp.acc(0, 0, 11'h7fd, 8'h00);
    `CHK("cp0 data", 8'h3c, crdata[7:0])
    u_cp.acc(1, 0, 11'h7fd, 8'h00);
    `CHK("cp1 data", 8'h5a, crdata[15:8])
  endtask
  // Vector posted by the control processor, cleared by the master read
  task t_vec;
    u_cp.acc(0, 1, 11'h7ff, 8'ha7);
    `CHK("irq_n set", 2'h2, irq_n)
    repeat (3) @(negedge clk_sys);
    `CHK("irq_n held", 2'h2, irq_n)
    m_acc(0, 0, 11'h7ff, 8'h00);
    `CHK("vector", 8'ha7, mrdata[7:0])
    `CHK("irq_n clr", 2'h3, irq_n)
  endtask
  // Master mailbox on both instances, acknowledged on the second only
  task t_mbx;
    m_acc(1, 1, 11'h7fe, 8'h11);
    `CHK("cp irq", 2'h2, irq)
    m_acc(0, 1, 11'h7fe, 8'h22);
    `CHK("cp irq both", 2'h3, irq)
    u_cp.acc(1, 0, 11'h7fe, 8'h00);
    `CHK("cp1 mailbox", 8'h11, crdata[15:8])
    `CHK("cp irq ack", 2'h1, irq)
  endtask
  // Frozen clock enable ignores a vector write; a live one posts it
  task t_freeze;
    cen = 1'h0;
    u_cp.acc(1, 1, 11'h7ff, 8'h5e);
    `CHK("irq_n frozen", 2'h3, irq_n)
    cen = 1'h1;
    u_cp.acc(1, 1, 11'h7ff, 8'h6b);
    `CHK("irq_n set 1", 2'h1, irq_n)
    m_acc(1, 0, 11'h7ff, 8'h00);
    `CHK("vector 1", 8'h6b, mrdata[15:8])
    `CHK("irq_n clr 1", 2'h3, irq_n)
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    sys_rst = 0;
    `CHK("irq_n reset", 2'h3, irq_n)
    t_boot;
    t_vec;
    t_freeze;
    t_mbx;
    final_report;
  end
endmodule
`default_nettype wire
